// >>> shared/spf_pkg.sv
// shared constants and types for the serial pin-function front end
package spf_pkg;
  // special-function register addresses
  localparam logic [7:0] CFG_ADDR = 8'h9c;
  localparam logic [7:0] CTL_ADDR = 8'hf8;
  localparam logic [7:0] DAT_ADDR = 8'hf7;
  // values after reset
  localparam logic [1:0] CFG_RST = 2'h0;
  localparam logic [5:0] CFG_RSVD = 6'h01;
  localparam logic [7:0] CTL_RST = 8'h04;
  localparam logic [7:0] DAT_RST = 8'h00;
  localparam logic [7:0] RDATA_RST = 8'h00;
  // pin_function_config field positions
  localparam int CFG_SER_EN = 0;
  localparam int CFG_EXT_CLK = 1;
  // serial_control_reg field positions
  localparam int CTL_DONE = 7;
  localparam int CTL_WCOL = 6;
  localparam int CTL_SERIAL_SELECT = 5;
  localparam int CTL_MASTER = 4;
  localparam int CTL_IDLE_LEVEL = 3;
  localparam int CTL_EDGE_PHASE = 2;
  localparam int CTL_RATE_HI = 1;
  localparam int CTL_RATE_LO = 0;
  // shared pin indices: a = serial clock / external clock, b = miso, c = mosi
  localparam int PIN_A = 0;
  localparam int PIN_B = 1;
  localparam int PIN_C = 2;
  // framing: eight bits, two clock edges per bit
  localparam logic [3:0] LAST_EDGE = 4'hf;
  localparam logic [3:0] EDGE_CNT_RST = 4'h0;
  localparam logic [2:0] DIV_RST = 3'h0;
  // crystal-locked core clock
  localparam longint CRYSTAL_HZ = 32768;
  localparam longint PLL_MULT = 512;
  localparam longint PLL_CORE_HZ = CRYSTAL_HZ * PLL_MULT;
  localparam logic [2:0] PINS_RELEASED = 3'h7;

  typedef enum logic [1:0] {
    SPF_MODE_PORT = 2'b00,
    SPF_MODE_MASTER = 2'b01,
    SPF_MODE_SLAVE = 2'b10,
    SPF_MODE_I2C = 2'b11
  } spf_mode_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } spf_sfr_req_t;

  typedef struct packed {
    logic [2:0] out;
    logic [2:0] oe_n;
  } spf_pin_drv_t;

  typedef struct packed {
    logic [7:0] tx;
    logic [7:0] rx;
    logic dout;
    logic [3:0] cnt;
  } spf_shift_st_t;

  // pin ownership from enable, serial select and master bits
  function automatic spf_mode_t pin_mode(input logic ser_en, input logic sel, input logic master);
    if (!ser_en)
      return SPF_MODE_PORT;
    else if (!sel)
      return SPF_MODE_I2C;
    else if (master)
      return SPF_MODE_MASTER;
    else
      return SPF_MODE_SLAVE;
  endfunction
endpackage

// >>> src/spf_sync.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/10ps
module spf_sync #(
  parameter int W = 4
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // levels
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } spf_sync_st_t;
  spf_sync_st_t q, d;

  always_comb begin
    d.meta = async_in;
    d.sync = q.meta;
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn)
      q <= '0;
    else
      q <= d;
  end

  assign sync_out = q.sync;
endmodule

// >>> src/spf_shifter.sv
// eight-bit full-duplex shift engine driven by serial clock edge strobes
`timescale 1ns/10ps
module spf_shifter (
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // control
  input wire logic load,
  input wire logic [7:0] load_data,
  input wire logic edge_phase,
  input wire logic abort,
  // serial clock edges
  input wire logic edge_stb,
  input wire logic edge_lead,
  // serial data
  input wire logic din,
  output logic dout,
  // status
  output logic busy,
  output logic done,
  output logic [7:0] rx_byte
);
  spf_pkg::spf_shift_st_t q, d;
  logic launch;

  always_comb begin
    d = q;
    done = 1'b0;
    launch = (edge_lead == edge_phase);
    if (load) begin
      d.cnt = spf_pkg::EDGE_CNT_RST;
      if (!edge_phase) begin
        d.dout = load_data[7];
        d.tx = {load_data[6:0], 1'b0};
      end else begin
        d.tx = load_data;
      end
    end else if (abort) begin
      d.cnt = spf_pkg::EDGE_CNT_RST;
    end else if (edge_stb) begin
      if (launch && q.cnt != spf_pkg::LAST_EDGE) begin
        d.dout = q.tx[7];
        d.tx = {q.tx[6:0], 1'b0};
      end
      if (!launch)
        d.rx = {q.rx[6:0], din};
      d.cnt = q.cnt + 4'h1;
      done = (q.cnt == spf_pkg::LAST_EDGE);
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn)
      q <= '0;
    else
      q <= d;
  end

  assign dout = q.dout;
  assign busy = (q.cnt != spf_pkg::EDGE_CNT_RST);
  assign rx_byte = d.rx;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  property p_msb_first;
    load && !edge_phase |=> dout == $past(load_data[7]);
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("first bit is not the msb");

  property p_sample_not_launch;
    edge_stb && !load && !abort && launch |=> q.rx == $past(q.rx);
  endproperty
  a_sample_not_launch: assert property (p_sample_not_launch) else $error("sampled on launch edge");
endmodule

// >>> src/spf_top.sv
// serial pin-function configuration, clock select and spi framing front end
// Functional notes
// - 8-bit config register at 0x9c, resets to 0x04, byte access only.
// - config bit 0 set routes serial interface onto three shared pins.
// - config bit 0 clear leaves shared pins as general-purpose port pins.
// - after reset, shared pins stay port pins until software enables serial.
// - config bit 1 selects external clock when 1, crystal plus pll when 0.
// - external clock enters on shared pin a, bypassing the pll.
// - external clock drives converter, memory, watchdog, serial and core clocks.
// - pll locks to crystal multiple for a 16.777216 MHz device clock.
// - with pins routed, serial select chooses spi or i2c operation.
// - eight bits move out and in simultaneously, full duplex.
// - miso is input as master, output as slave.
// - mosi is output as master, input as slave.
// - each transfer is one byte, msb first, on both data lines.
// - one bit each way per serial clock period; eight periods per byte.
// - serial clock pin driven as master, input as slave.
// - master clock rate, idle level and phase follow control bits.
// - data launched on one serial clock edge, sampled on the other.
// - serial select set enables spi, clear enables i2c.
// - idle level bit set idles clock high, clear idles it low.
// - master rate codes 00..11 divide core clock by 2, 4, 8, 16.
`timescale 1ns/10ps
module spf_top (
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // special-function register port
  input wire spf_pkg::spf_sfr_req_t sfr_req,
  output logic [7:0] sfr_rdata,
  // port 3 latch side
  input wire logic [2:0] port_dout,
  input wire logic [2:0] port_drv_en,
  output logic [2:0] port_pin_level,
  // shared pins
  input wire logic [2:0] pin_in,
  output logic [2:0] pin_out,
  output logic [2:0] pin_oe_n,
  input wire logic slave_select_n,
  // clock unit and serial select
  output logic external_clock_select,
  output logic pll_enable,
  output logic i2c_select
);
  typedef struct packed {
    logic [1:0] cfg;
    logic [7:0] ctl;
    logic [7:0] dat;
    logic [7:0] rdata;
    logic run;
    logic sclk;
    logic [2:0] div;
    logic sclk_prev;
    logic [2:0] smp;
    logic [2:0] fin;
    logic [7:0] mrx;
    spf_pkg::spf_pin_drv_t pins;
  } spf_top_st_t;

  spf_top_st_t q, d;
  spf_pkg::spf_mode_t mode;
  logic [3:0] sync_q;
  logic ss_n_s;
  logic sclk_s;
  logic wr_cfg, wr_ctl, wr_dat, rd_cfg, rd_ctl, rd_dat;
  logic sh_load, sh_abort, sh_edge, sh_lead, sh_din, sh_dout, sh_busy, sh_done;
  logic [7:0] sh_rx;
  logic [2:0] half_m1;
  logic busy;

  spf_sync #(
    .W(4)
  ) u_sync (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .async_in({slave_select_n, pin_in}),
    .sync_out(sync_q)
  );

  assign ss_n_s = sync_q[3];
  assign sclk_s = sync_q[spf_pkg::PIN_A];
  assign port_pin_level = sync_q[2:0];

  assign mode = spf_pkg::pin_mode(q.cfg[spf_pkg::CFG_SER_EN], q.ctl[spf_pkg::CTL_SERIAL_SELECT],
    q.ctl[spf_pkg::CTL_MASTER]);
  assign wr_cfg = sfr_req.wr && sfr_req.addr == spf_pkg::CFG_ADDR;
  assign wr_ctl = sfr_req.wr && sfr_req.addr == spf_pkg::CTL_ADDR;
  assign wr_dat = sfr_req.wr && sfr_req.addr == spf_pkg::DAT_ADDR;
  assign rd_cfg = sfr_req.rd && sfr_req.addr == spf_pkg::CFG_ADDR;
  assign rd_ctl = sfr_req.rd && sfr_req.addr == spf_pkg::CTL_ADDR;
  assign rd_dat = sfr_req.rd && sfr_req.addr == spf_pkg::DAT_ADDR;
  assign busy = q.run || sh_busy || (q.fin != 3'h0);
  assign sh_load = wr_dat && !busy;
  // half serial clock period in core cycles, minus one
  assign half_m1 = 3'((4'h1 << {q.ctl[spf_pkg::CTL_RATE_HI], q.ctl[spf_pkg::CTL_RATE_LO]}) - 4'h1);
  assign sh_din = (mode == spf_pkg::SPF_MODE_MASTER) ? sync_q[spf_pkg::PIN_B] : sync_q[spf_pkg::PIN_C];

  spf_shifter u_shift (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .load(sh_load),
    .load_data(sfr_req.wdata),
    .edge_phase(q.ctl[spf_pkg::CTL_EDGE_PHASE]),
    .abort(sh_abort),
    .edge_stb(sh_edge),
    .edge_lead(sh_lead),
    .din(sh_din),
    .dout(sh_dout),
    .busy(sh_busy),
    .done(sh_done),
    .rx_byte(sh_rx)
  );

  always_comb begin
    d = q;
    sh_edge = 1'b0;
    sh_lead = 1'b0;
    sh_abort = 1'b0;
    d.sclk_prev = sclk_s;
    // register writes
    if (wr_cfg)
      d.cfg = sfr_req.wdata[1:0];
    if (wr_ctl)
      d.ctl = sfr_req.wdata;
    if (wr_dat && busy)
      d.ctl[spf_pkg::CTL_WCOL] = 1'b1;
    if (sh_load) begin
      d.dat = sfr_req.wdata;
      d.run = (mode == spf_pkg::SPF_MODE_MASTER);
    end
    // register reads
    if (rd_dat)
      d.ctl[spf_pkg::CTL_DONE] = 1'b0;
    if (rd_cfg)
      d.rdata = {spf_pkg::CFG_RSVD, q.cfg};
    else if (rd_ctl)
      d.rdata = (mode == spf_pkg::SPF_MODE_SLAVE) ? {q.ctl[7:1], ss_n_s} : q.ctl;
    else if (rd_dat)
      d.rdata = q.dat;
    // serial clock generation and edge detection
    case (mode)
      spf_pkg::SPF_MODE_MASTER: begin
        if (q.run) begin
          if (q.div == half_m1) begin
            d.div = spf_pkg::DIV_RST;
            d.sclk = ~q.sclk;
            sh_edge = 1'b1;
            sh_lead = (q.sclk == q.ctl[spf_pkg::CTL_IDLE_LEVEL]);
          end else begin
            d.div = q.div + 3'h1;
          end
        end else begin
          d.div = spf_pkg::DIV_RST;
          d.sclk = q.ctl[spf_pkg::CTL_IDLE_LEVEL];
          sh_abort = 1'b1;
        end
      end
      spf_pkg::SPF_MODE_SLAVE: begin
        d.sclk = q.ctl[spf_pkg::CTL_IDLE_LEVEL];
        d.div = spf_pkg::DIV_RST;
        d.run = 1'b0;
        sh_abort = ss_n_s;
        sh_edge = !ss_n_s && (sclk_s != q.sclk_prev);
        sh_lead = (q.sclk_prev == q.ctl[spf_pkg::CTL_IDLE_LEVEL]);
      end
      default: begin
        d.sclk = q.ctl[spf_pkg::CTL_IDLE_LEVEL];
        d.div = spf_pkg::DIV_RST;
        d.run = 1'b0;
        sh_abort = 1'b1;
      end
    endcase
    // master miso comes back through pin register and sync: capture three cycles late
    d.smp = {q.smp[1:0], (mode == spf_pkg::SPF_MODE_MASTER) && sh_edge &&
      (sh_lead != q.ctl[spf_pkg::CTL_EDGE_PHASE])};
    d.fin = {q.fin[1:0], (mode == spf_pkg::SPF_MODE_MASTER) && sh_done};
    if (q.smp[2])
      d.mrx = {q.mrx[6:0], sync_q[spf_pkg::PIN_B]};
    if (sh_done)
      d.run = 1'b0;
    // end of byte: latch received data, set flag (set wins over clear)
    if (q.fin[2]) begin
      d.dat = q.smp[2] ? {q.mrx[6:0], sync_q[spf_pkg::PIN_B]} : q.mrx;
      d.ctl[spf_pkg::CTL_DONE] = 1'b1;
    end else if (sh_done && mode != spf_pkg::SPF_MODE_MASTER) begin
      d.dat = sh_rx;
      d.ctl[spf_pkg::CTL_DONE] = 1'b1;
    end
    // pin ownership
    case (mode)
      spf_pkg::SPF_MODE_PORT: begin
        d.pins.out = port_dout;
        d.pins.oe_n = ~port_drv_en;
      end
      spf_pkg::SPF_MODE_MASTER: begin
        d.pins.out = {sh_dout, 1'b0, q.sclk};
        d.pins.oe_n = {1'b0, 1'b1, 1'b0};
      end
      spf_pkg::SPF_MODE_SLAVE: begin
        d.pins.out = {1'b0, sh_dout, 1'b0};
        d.pins.oe_n = {1'b1, ss_n_s, 1'b1};
      end
      default: begin
        d.pins.out = 3'h0;
        d.pins.oe_n = spf_pkg::PINS_RELEASED;
      end
    endcase
    if (q.cfg[spf_pkg::CFG_EXT_CLK])
      d.pins.oe_n[spf_pkg::PIN_A] = 1'b1;
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      q <= '0;
      q.cfg <= spf_pkg::CFG_RST;
      q.ctl <= spf_pkg::CTL_RST;
      q.dat <= spf_pkg::DAT_RST;
      q.rdata <= spf_pkg::RDATA_RST;
      q.pins.oe_n <= spf_pkg::PINS_RELEASED;
    end else begin
      q <= d;
    end
  end

  assign sfr_rdata = q.rdata;
  assign pin_out = q.pins.out;
  assign pin_oe_n = q.pins.oe_n;
  assign external_clock_select = q.cfg[spf_pkg::CFG_EXT_CLK];
  assign pll_enable = ~q.cfg[spf_pkg::CFG_EXT_CLK];
  assign i2c_select = (mode == spf_pkg::SPF_MODE_I2C);

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  property p_cfg_read;
    rd_cfg && !sfr_req.wr |=> sfr_rdata == {spf_pkg::CFG_RSVD, $past(q.cfg)};
  endproperty
  a_cfg_read: assert property (p_cfg_read) else $error("config read value wrong");

  property p_cfg_rsvd;
    wr_cfg ##1 rd_cfg |=> sfr_rdata[7:2] == spf_pkg::CFG_RSVD;
  endproperty
  a_cfg_rsvd: assert property (p_cfg_rsvd) else $error("reserved config bits changed");

  property p_ext_sel;
    wr_cfg |=> external_clock_select == $past(sfr_req.wdata[1]) && pll_enable != external_clock_select;
  endproperty
  a_ext_sel: assert property (p_ext_sel) else $error("clock select does not follow bit 1");

  property p_ext_pin;
    external_clock_select |=> pin_oe_n[spf_pkg::PIN_A];
  endproperty
  a_ext_pin: assert property (p_ext_pin) else $error("external clock pin driven");

  property p_port_mode;
    mode == spf_pkg::SPF_MODE_PORT && !external_clock_select |=>
      pin_out == $past(port_dout) && pin_oe_n == ~$past(port_drv_en);
  endproperty
  a_port_mode: assert property (p_port_mode) else $error("port pins not under port control");

  property p_master_dir;
    mode == spf_pkg::SPF_MODE_MASTER |=> pin_oe_n[spf_pkg::PIN_B] && !pin_oe_n[spf_pkg::PIN_C];
  endproperty
  a_master_dir: assert property (p_master_dir) else $error("master data pin direction wrong");

  property p_slave_dir;
    mode == spf_pkg::SPF_MODE_SLAVE |=> pin_oe_n[spf_pkg::PIN_A] && pin_oe_n[spf_pkg::PIN_C];
  endproperty
  a_slave_dir: assert property (p_slave_dir) else $error("slave clock or mosi driven");

  property p_i2c_release;
    mode == spf_pkg::SPF_MODE_I2C |=> pin_oe_n == spf_pkg::PINS_RELEASED;
  endproperty
  a_i2c_release: assert property (p_i2c_release) else $error("pins driven in i2c mode");

  property p_idle_level;
    mode == spf_pkg::SPF_MODE_MASTER && !q.run && !wr_ctl ##1 !q.run |-> q.sclk == q.ctl[spf_pkg::CTL_IDLE_LEVEL];
  endproperty
  a_idle_level: assert property (p_idle_level) else $error("serial clock not at idle level");

  property p_rate_16;
    mode == spf_pkg::SPF_MODE_MASTER && q.run && q.ctl[1:0] == 2'b11 && !wr_ctl && $changed(q.sclk)
      |=> $stable(q.sclk) [*7];
  endproperty
  a_rate_16: assert property (p_rate_16) else $error("divide by 16 half period wrong");

  property p_burst_len;
    sh_load && mode == spf_pkg::SPF_MODE_MASTER && q.ctl[1:0] == 2'b00 |-> ##16 sh_done;
  endproperty
  a_burst_len: assert property (p_burst_len) else $error("byte not eight clock periods");

  c_master_done: cover property (mode == spf_pkg::SPF_MODE_MASTER && sh_done);
  c_slave_done: cover property (mode == spf_pkg::SPF_MODE_SLAVE && sh_done);
  c_collision: cover property (wr_dat && busy);
endmodule

// >>> dv/spf_far_slave.sv
// behavioural spi slave standing on the far side of the shared pins
`timescale 1ns/10ps
module spf_far_slave (
  // pins
  input wire logic sclk,
  input wire logic mosi,
  input wire logic sel_n,
  output logic miso,
  // settings and data
  input wire logic idle_level,
  input wire logic edge_phase,
  input wire logic slow,
  input wire logic [7:0] tx_byte,
  output logic [7:0] rx_byte
);
  logic [7:0] sh;
  logic prev;

  initial begin
    sh = 8'h00;
    prev = 1'b0;
    miso = 1'b0;
    rx_byte = 8'h00;
  end

  // msb ready before the first edge for phase 0
  always @(negedge sel_n) begin
    sh = tx_byte;
    miso <= #(slow ? 15 : 1) tx_byte[7];
    prev = sclk;
  end

  // released line shows no stale level
  always @(posedge sel_n) miso <= #1 ~miso;

  always @(sclk) begin
    if (!sel_n && sclk !== prev) begin
      prev = sclk;
      if ((sclk != idle_level) == edge_phase) begin
        if (!edge_phase)
          sh = {sh[6:0], 1'b0};
        miso <= #(slow ? 15 : 1) sh[7];
        if (edge_phase)
          sh = {sh[6:0], 1'b0};
      end else begin
        rx_byte = {rx_byte[6:0], mosi};
      end
    end
  end
endmodule

// >>> dv/spi_pin_setup_and_framing_tb_top.sv
// self-checking bench for the serial pin-function front end
`timescale 1ns/10ps
module spi_pin_setup_and_framing_tb_top;
  typedef struct packed {
    logic [7:0] cfg;
    logic [7:0] ctl;
    logic [2:0] pdo;
    logic [2:0] pde;
    logic ssel_n;
    logic [2:0] oe;
    logic [2:0] out;
    logic [2:0] om;
    logic [2:0] flg;
    logic [7:0] rb;
  } spf_row_t;
  localparam int LIMIT = 4000;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  spf_pkg::spf_sfr_req_t req = '0;
  logic [2:0] port_dout = 3'h5;
  logic [2:0] port_drv_en = 3'h7;
  logic [2:0] ext_lvl = 3'h6;
  logic ssel_n = 1'b1;
  logic s_sel_n = 1'b1;
  logic s_pol = 1'b0;
  logic s_ph = 1'b0;
  logic s_slow = 1'b0;
  logic [7:0] s_tx = 8'h00;
  logic [7:0] sfr_rdata, s_rx;
  logic [2:0] port_pin_level, pin_in, pin_out, pin_oe_n;
  logic ext_sel, pll_en, i2c_sel, miso;
  logic sclk_prev = 1'b0;
  int n_errors = 0, total_checks = 0, cyc = 0, n_edges = 0, first_cyc = 0, last_cyc = 0;
  spf_row_t rows [8];

  always #20 ref_clk = ~ref_clk;

  // wire levels from every party's enable
  assign pin_in[0] = !pin_oe_n[0] ? pin_out[0] : ext_lvl[0];
  assign pin_in[1] = !pin_oe_n[1] ? pin_out[1] : (!s_sel_n ? miso : ext_lvl[1]);
  assign pin_in[2] = !pin_oe_n[2] ? pin_out[2] : ext_lvl[2];

  spf_top uut (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .sfr_req(req),
    .sfr_rdata(sfr_rdata),
    .port_dout(port_dout),
    .port_drv_en(port_drv_en),
    .port_pin_level(port_pin_level),
    .pin_in(pin_in),
    .pin_out(pin_out),
    .pin_oe_n(pin_oe_n),
    .slave_select_n(ssel_n),
    .external_clock_select(ext_sel),
    .pll_enable(pll_en),
    .i2c_select(i2c_sel)
  );

  spf_far_slave far (
    .sclk(pin_in[0]),
    .mosi(pin_in[2]),
    .sel_n(s_sel_n),
    .miso(miso),
    .idle_level(s_pol),
    .edge_phase(s_ph),
    .slow(s_slow),
    .tx_byte(s_tx),
    .rx_byte(s_rx)
  );

  task automatic conclude();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    #2 req = '{1'b1, 1'b0, a, d};
    @(posedge ref_clk);
    #2 req.wr = 1'b0;
  endtask

  task automatic sfr_rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(posedge ref_clk);
    #2 req = '{1'b0, 1'b1, a, 8'h00};
    @(posedge ref_clk);
    #2 req.rd = 1'b0;
    @(posedge ref_clk);
    #2 chk(sfr_rdata, exp, what);
  endtask

  task automatic do_reset();
    #2 resetn = 1'b0;
    repeat (12) @(posedge ref_clk);
    #2 chk({5'h0, pin_oe_n}, 8'h07, "pins in reset");
    chk({5'h0, ext_sel, pll_en, i2c_sel}, 8'h02, "clock select in reset");
    chk(sfr_rdata, 8'h00, "read data in reset");
    resetn = 1'b1;
    repeat (2) @(posedge ref_clk);
    #2 chk({5'h0, pin_oe_n}, {5'h0, ~port_drv_en}, "port direction after reset");
    chk({5'h0, pin_out}, {5'h0, port_dout}, "port values after reset");
    sfr_rd(spf_pkg::CFG_ADDR, 8'h04, "config reset");
    sfr_rd(spf_pkg::DAT_ADDR, 8'h00, "data reset");
    sfr_rd(spf_pkg::CTL_ADDR, 8'h04, "control reset");
  endtask

  task automatic xfer(input logic [1:0] r, input logic pol, input logic ph, input logic [7:0] mtx,
                      input logic [7:0] stx, input logic coll);
    logic [7:0] c;
    c = {4'h3, pol, ph, r};
    s_pol = pol;
    s_ph = ph;
    s_slow = r[1];
    s_tx = stx;
    sfr_wr(spf_pkg::CTL_ADDR, c);
    repeat (3) @(posedge ref_clk);
    #2 s_sel_n = 1'b0;
    n_edges = 0;
    sfr_wr(spf_pkg::DAT_ADDR, mtx);
    // second write lands while the byte is in flight
    if (coll) begin
      repeat (40) @(posedge ref_clk);
      sfr_wr(spf_pkg::DAT_ADDR, 8'hff);
    end
    repeat ((16 << r) + 2 - (coll ? 42 : 0)) @(posedge ref_clk);
    sfr_rd(spf_pkg::CTL_ADDR, c | (coll ? 8'hc0 : 8'h80), "done flag");
    sfr_rd(spf_pkg::DAT_ADDR, stx, "received byte");
    sfr_rd(spf_pkg::CTL_ADDR, c | (coll ? 8'h40 : 8'h00), "flag after data read");
    chk(s_rx, mtx, "byte at far side");
    chk(8'(n_edges), 8'h10, "clock edges");
    chk(8'(last_cyc - first_cyc), 8'(15 << r), "clock span");
    chk({7'h0, pin_out[0]}, {7'h0, pol}, "clock idle level");
    s_sel_n = 1'b1;
    if (coll) begin
      sfr_wr(spf_pkg::CTL_ADDR, c);
      sfr_rd(spf_pkg::CTL_ADDR, c, "collision cleared");
    end
  endtask

  // serial clock edges seen on pin a while driven
  always @(negedge ref_clk) begin
    if (!pin_oe_n[0] && pin_out[0] !== sclk_prev) begin
      if (n_edges == 0)
        first_cyc = cyc;
      last_cyc = cyc;
      n_edges++;
    end
    sclk_prev = pin_out[0];
  end

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc >= LIMIT) begin
      n_errors++;
      $display("BAD %0t run did not finish", $time);
      conclude();
    end
  end

  initial begin
    rows[0] = '{8'h00, 8'h04, 3'h5, 3'h7, 1'b1, 3'h0, 3'h5, 3'h7, 3'b010, 8'h04};
    rows[1] = '{8'hfc, 8'h04, 3'h2, 3'h2, 1'b1, 3'h5, 3'h2, 3'h2, 3'b010, 8'h04};
    rows[2] = '{8'h02, 8'h04, 3'h6, 3'h6, 1'b1, 3'h1, 3'h6, 3'h6, 3'b100, 8'h06};
    rows[3] = '{8'h01, 8'h30, 3'h0, 3'h0, 1'b1, 3'h2, 3'h0, 3'h1, 3'b010, 8'h05};
    rows[4] = '{8'h01, 8'h38, 3'h0, 3'h0, 1'b1, 3'h2, 3'h1, 3'h1, 3'b010, 8'h05};
    rows[5] = '{8'h01, 8'h20, 3'h0, 3'h0, 1'b1, 3'h7, 3'h0, 3'h0, 3'b010, 8'h05};
    rows[6] = '{8'h01, 8'h20, 3'h0, 3'h0, 1'b0, 3'h5, 3'h0, 3'h0, 3'b010, 8'h05};
    rows[7] = '{8'h01, 8'h00, 3'h0, 3'h0, 1'b1, 3'h7, 3'h0, 3'h0, 3'b011, 8'h05};
    do_reset();
    sfr_wr(8'h9d, 8'hff);
    sfr_rd(8'h9d, 8'h04, "unmapped read holds");
    sfr_rd(spf_pkg::CFG_ADDR, 8'h04, "config after unmapped write");
    foreach (rows[i]) begin
      sfr_wr(spf_pkg::CFG_ADDR, rows[i].cfg);
      sfr_wr(spf_pkg::CTL_ADDR, rows[i].ctl);
      port_dout = rows[i].pdo;
      port_drv_en = rows[i].pde;
      ssel_n = rows[i].ssel_n;
      repeat (5) @(posedge ref_clk);
      #2 chk({5'h0, pin_oe_n}, {5'h0, rows[i].oe}, "pin direction");
      chk({5'h0, pin_out & rows[i].om}, {5'h0, rows[i].out & rows[i].om}, "pin value");
      chk({5'h0, port_pin_level}, {5'h0, pin_in}, "pin level");
      chk({5'h0, ext_sel, pll_en, i2c_sel}, {5'h0, rows[i].flg}, "mode outputs");
      sfr_rd(spf_pkg::CFG_ADDR, rows[i].rb, "config readback");
    end
    ssel_n = 1'b1;
    sfr_wr(spf_pkg::CFG_ADDR, 8'h01);
    xfer(2'd0, 1'b0, 1'b0, 8'ha5, 8'h3c, 1'b0);
    xfer(2'd1, 1'b1, 1'b1, 8'h81, 8'h7e, 1'b0);
    xfer(2'd2, 1'b0, 1'b1, 8'h4b, 8'hd2, 1'b0);
    xfer(2'd3, 1'b1, 1'b0, 8'h1f, 8'he0, 1'b0);
    xfer(2'd3, 1'b0, 1'b0, 8'h5a, 8'h96, 1'b1);
    // reset lands in the middle of a byte
    #2 s_sel_n = 1'b0;
    sfr_wr(spf_pkg::DAT_ADDR, 8'h77);
    repeat (30) @(posedge ref_clk);
    port_drv_en = 3'h3;
    do_reset();
    s_sel_n = 1'b1;
    conclude();
  end
endmodule
